// ===== verilog/gtp_pkg.sv
// Package of constants and carrier types for the gated timer / PWM block
package gtp_pkg;

	// ************************************************************
	// Widths and reset values
	// ************************************************************
	localparam int unsigned  CNT_W     = 16;
	localparam logic [15:0]  PER_RST   = 16'hffff;
	localparam logic [15:0]  CMP_RST   = 16'h0000;
	localparam logic [15:0]  CNT_RST   = 16'h0000;
	localparam logic [15:0]  TC_VALUE  = 16'h0000;

	// ************************************************************
	// Submode field encodings
	// ************************************************************
	localparam logic [2:0] SUB_FREE   = 3'h0;
	localparam logic [2:0] SUB_PULSE  = 3'h1;
	localparam logic [2:0] SUB_PERIOD = 3'h2;
	localparam logic [2:0] SUB_IRQ    = 3'h3;
	localparam logic [2:0] CMP_EQ     = 3'h0;
	localparam logic [2:0] CMP_LT     = 3'h1;
	localparam logic [2:0] CMP_LE     = 3'h2;
	localparam logic [2:0] CMP_GT     = 3'h3;
	localparam logic [2:0] CMP_GE     = 3'h4;

	// Software configuration bits, held by the caller
	typedef struct packed {
		logic        pwm_mode;      // Function select: 1 = comparator
		logic [2:0]  submode;
		logic        one_shot;
		logic        dead_time_on;
		logic        enable_inv;
	} gtp_cfg_t;

	// Interrupt enables
	typedef struct packed {
		logic tc;
		logic cmp;
		logic stop;
	} gtp_irq_en_t;

	// Sticky status flags
	typedef struct packed {
		logic tc;
		logic cmp;
		logic halted_flag;
	} gtp_status_t;

endpackage : gtp_pkg

// ===== verilog/gtp_timer.sv
// Gated timer and PWM comparator block, 16-bit down counter
// Overview of operation
// - Submode 011 runs counter from run gate set until an enabled terminal count interrupt.
// - Setting run gate loads count register from period register.
// - Counter counts down; count register holds current time.
// - Measure starts on enable rise; stops on fall or next rise.
// - Terminal count in gated modes reloads the period value, unless it ends an irq-mode run.
// - Timer stop raises stop interrupt only when enabled.
// - Sticky halted flag set on stop; software clears it.
// - Enable edges detected with two clock cycle latency.
// - Sixteen-bit count read returns count and copies it to capture.
// - Low byte read copies both count bytes into capture.
// - Without one-shot restart on next rise; with it halt.
// - Stop-on-interrupt: run on gate, clear gate on an enabled terminal count interrupt.
// - Function select one chooses comparator mode; submode picks test.
// - Compare types: 000 eq, 001 lt, 010 le, 011 gt, 100 ge.
// - PWM period is period value plus one, times one clock period.
// - True compare drives output or interrupt; counter keeps reloading.
// - Compare interrupt gated by its enable bit.
// - Dead time on in comparator mode: tc output is inverted compare.
// - Count register unreadable in comparator mode.
// - Equal type gives one-cycle compare pulse and interrupt.
// - Less-than rises below compare, falls at terminal count.
// - Less-or-equal rises at equality, falls at terminal count.
// - Greater-than rises at reload, falls at compare plus one.
// - Greater-or-equal rises at reload, falls at compare value.
`timescale 1ns/10ps

module gtp_timer #(
	parameter int unsigned W = gtp_pkg::CNT_W
) (
	// Clock, reset, clock enable
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              clk_en,
	// Configuration
	input  wire gtp_pkg::gtp_cfg_t    cfg,
	input  wire gtp_pkg::gtp_irq_en_t irq_en,
	input  wire logic [W-1:0]      period_val,
	input  wire logic [W-1:0]      compare_val,
	// Run gate: set and clear pulses from software
	input  wire logic              run_set,
	input  wire logic              run_clr,
	// Status clear, one bit per flag
	input  wire gtp_pkg::gtp_status_t status_clr,
	// Count read strobes
	input  wire logic              rd_cnt16,
	input  wire logic              rd_cnt_lo,
	// Enable pin, asynchronous to clk
	input  wire logic              enable_pin,
	// Outputs
	output logic                   run_gate,
	output logic [W-1:0]           count_register,
	output logic [W-1:0]           rd_data,
	output logic [W-1:0]           capture_r,
	output gtp_pkg::gtp_status_t   status_r,
	output logic                   irq_out,
	output logic                   cmp_out,
	output logic                   tc_out
);

	// ************************************************************
	// Enable pin synchroniser and edge detect
	// ************************************************************
	logic en_s1_r, en_s2_r, en_d_r;
	logic en_lvl, en_rise, en_fall;

	// Two-stage sync; only the second stage feeds logic
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			en_s1_r <= 1'b0;
			en_s2_r <= 1'b0;
			en_d_r  <= 1'b0;
		end else if (clk_en) begin
			en_s1_r <= enable_pin;
			en_s2_r <= en_s1_r;
			en_d_r  <= en_lvl;
		end
	end

	assign en_lvl  = en_s2_r ^ cfg.enable_inv;
	assign en_rise = en_lvl & ~en_d_r;
	assign en_fall = ~en_lvl & en_d_r;

	// ************************************************************
	// Mode decode and counter control
	// ************************************************************
	logic gated, is_pulse, is_period, is_irqm;
	logic counting_r, armed_r, seen_start_r;
	logic at_tc, start_ev, stop_ev, irq_ev, cmp_hit;
	logic tc_ev, stop_pulse;

	assign gated     = ~cfg.pwm_mode;
	assign is_pulse  = gated & (cfg.submode == gtp_pkg::SUB_PULSE);
	assign is_period = gated & (cfg.submode == gtp_pkg::SUB_PERIOD);
	assign is_irqm   = gated & (cfg.submode == gtp_pkg::SUB_IRQ);
	assign at_tc     = (count_register == W'(gtp_pkg::TC_VALUE));
	assign tc_ev     = run_gate & counting_r & at_tc;

	// Measure start and stop edges
	assign start_ev = (is_pulse | is_period) & armed_r & en_rise;
	assign stop_ev  = counting_r & ((is_pulse & en_fall) |
		(is_period & en_rise & seen_start_r));

	// Enabled terminal count or compare source, raw
	assign irq_ev = (irq_en.tc & tc_ev) | (irq_en.cmp & cmp_hit);

	// Irq-mode stop: only an enabled terminal count interrupt ends the run, as compare never hits in a gated mode
	logic irqm_stop;
	assign irqm_stop = is_irqm & counting_r & irq_ev;

	// Stop pulse covers measure stops and irq-mode stop
	assign stop_pulse = stop_ev | irqm_stop;

	// Run gate: set by software, cleared by software, irq mode or one-shot end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_gate <= 1'b0;
		end else if (clk_en) begin
			if (run_set)
				run_gate <= 1'b1;
			else if (run_clr)
				run_gate <= 1'b0;
			else if (irqm_stop)
				run_gate <= 1'b0;
			else if (cfg.one_shot & stop_ev)
				run_gate <= 1'b0;
			else if (cfg.one_shot & ~(is_pulse | is_period) & tc_ev)
				run_gate <= 1'b0;
		end
	end

	// Counting state: armed waits for a start edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			counting_r   <= 1'b0;
			armed_r      <= 1'b0;
			seen_start_r <= 1'b0;
		end else if (clk_en) begin
			if (run_set) begin
				// Free-run, irq and pwm modes start at once
				counting_r   <= ~(is_pulse | is_period);
				armed_r      <= is_pulse | is_period;
				seen_start_r <= 1'b0;
			end else if (~run_gate | run_clr) begin
				counting_r <= 1'b0;
				armed_r    <= 1'b0;
			end else if (stop_pulse) begin
				counting_r <= 1'b0;
				// Rearm for the next rise unless one-shot or irq mode
				armed_r    <= ~cfg.one_shot & ~is_irqm;
				seen_start_r <= 1'b0;
			end else if (start_ev) begin
				counting_r   <= 1'b1;
				armed_r      <= 1'b0;
				seen_start_r <= 1'b1;
			end
		end
	end

	// The start edge itself counts, so the count moves by the full
	// pulse width or period; the stopping edge does not
	logic cnt_step;
	assign cnt_step = run_gate & (counting_r | start_ev) & ~stop_pulse;

	// Down counter with reload at terminal count
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_register <= W'(gtp_pkg::CNT_RST);
		end else if (clk_en) begin
			if (run_set)
				count_register <= period_val;
			else if (tc_ev & ~stop_pulse)
				count_register <= period_val;
			else if (cnt_step)
				count_register <= count_register - W'(1);
		end
	end

	// ************************************************************
	// Comparator and outputs
	// ************************************************************
	logic eq, le, eq_p1, reload_ev, cmp_nxt, cmp_run;

	// Compare terms against the live count
	assign eq        = count_register == compare_val;
	assign le        = count_register <= compare_val;
	// Wraps at full scale, so a compare at the top sees plus one at count zero
	assign eq_p1     = count_register == compare_val + W'(1);
	assign reload_ev = cfg.pwm_mode & tc_ev;
	assign cmp_run   = cfg.pwm_mode & run_gate & counting_r;

	// Interrupt moment per compare type
	always_comb begin
		cmp_hit = 1'b0;
		if (cmp_run) begin
			unique case (cfg.submode)
				gtp_pkg::CMP_EQ: begin
					cmp_hit = eq;
				end
				gtp_pkg::CMP_LT: begin
					// Fires once, on the cycle the output rises
					cmp_hit = le & ~cmp_out & ~at_tc;
				end
				gtp_pkg::CMP_LE: begin
					cmp_hit = eq;
				end
				gtp_pkg::CMP_GT: begin
					cmp_hit = at_tc;
				end
				gtp_pkg::CMP_GE: begin
					cmp_hit = at_tc;
				end
				default: begin
					cmp_hit = 1'b0;
				end
			endcase
		end
	end

	// Output level per type, aligned with the count it describes.
	// Held while stopped, so a disabled level type keeps its last level, high or low.
	always_comb begin
		if (cfg.submode == gtp_pkg::CMP_EQ)
			cmp_nxt = 1'b0;  // A pulse type must never freeze high
		else
			cmp_nxt = cmp_out;
		if (cmp_run) begin
			unique case (cfg.submode)
				gtp_pkg::CMP_EQ: begin
					cmp_nxt = eq;
				end
				gtp_pkg::CMP_LT: begin
					// Rises as the count drops below compare
					cmp_nxt = at_tc ? 1'b0 : (le | cmp_out);
				end
				gtp_pkg::CMP_LE: begin
					cmp_nxt = at_tc ? 1'b0 : (eq_p1 | cmp_out);
				end
				gtp_pkg::CMP_GT: begin
					if (reload_ev)
						cmp_nxt = 1'b1;
					else if (eq_p1)
						cmp_nxt = 1'b0;
				end
				gtp_pkg::CMP_GE: begin
					if (reload_ev)
						cmp_nxt = 1'b1;
					else if (eq)
						cmp_nxt = 1'b0;
				end
				default: begin
					cmp_nxt = 1'b0;
				end
			endcase
		end
	end

	// Registered compare output; cleared outside comparator mode
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmp_out <= 1'b0;
		end else if (clk_en) begin
			if (cfg.pwm_mode)
				cmp_out <= cmp_nxt;
			else
				cmp_out <= 1'b0;
		end
	end

	// Terminal count pulse, or the compare complement with dead time.
	// Built from the same next value so the pair never skews.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tc_out <= 1'b0;
		end else if (clk_en) begin
			if (cfg.pwm_mode & cfg.dead_time_on)
				tc_out <= ~cmp_nxt;
			else
				tc_out <= tc_ev;
		end
	end

	// ************************************************************
	// Sticky status and interrupt output
	// ************************************************************
	// Set wins over clear in the same cycle, so no event is lost
	// when software clears a flag just as it fires again
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			status_r <= '0;
		end else if (clk_en) begin
			status_r.tc <= tc_ev | (status_r.tc & ~status_clr.tc);
			// Compare flag follows the per-type interrupt moment
			status_r.cmp <= cmp_hit | (status_r.cmp & ~status_clr.cmp);
			status_r.halted_flag <= stop_pulse |
				(status_r.halted_flag & ~status_clr.halted_flag);
		end
	end

	// Level interrupt from enabled sticky flags
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_out <= 1'b0;
		end else if (clk_en) begin
			irq_out <= (irq_en.stop & status_r.halted_flag)
				| (irq_en.cmp & status_r.cmp)
				| (irq_en.tc & status_r.tc);
		end
	end

	// ************************************************************
	// Count read and capture
	// ************************************************************
	// Read data: the compare value hides the count in comparator mode
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= '0;
		end else if (clk_en) begin
			if (cfg.pwm_mode)
				rd_data <= compare_val;
			else if (rd_cnt16)
				rd_data <= count_register;
			else if (rd_cnt_lo)
				rd_data <= {{(W-8){1'b0}}, count_register[7:0]};
		end
	end

	// Capture freezes the whole count on either read width, so a low
	// byte read followed by capture reads gives a coherent value
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			capture_r <= '0;
		end else if (clk_en) begin
			if (~cfg.pwm_mode & (rd_cnt16 | rd_cnt_lo))
				capture_r <= count_register;
		end
	end

endmodule : gtp_timer

// ===== tb/gtp_timer_checker.sv
// Port-level assertions for the gated timer / PWM block
`timescale 1ns/10ps
module gtp_timer_checker #(
	parameter int unsigned W = 16
) (
	// Clock and control
	input wire logic                 clk,
	input wire logic                 reset_n,
	input wire logic                 clk_en,
	input wire gtp_pkg::gtp_cfg_t    cfg,
	input wire gtp_pkg::gtp_irq_en_t irq_en,
	input wire logic [W-1:0]         period_val,
	input wire logic [W-1:0]         compare_val,
	input wire logic                 run_set,
	input wire gtp_pkg::gtp_status_t status_clr,
	input wire logic                 rd_cnt16,
	input wire logic                 rd_cnt_lo,
	// Outputs watched
	input wire logic                 run_gate,
	input wire logic [W-1:0]         count_register,
	input wire logic [W-1:0]         rd_data,
	input wire logic [W-1:0]         capture_r,
	input wire gtp_pkg::gtp_status_t status_r,
	input wire logic                 irq_out,
	input wire logic                 cmp_out,
	input wire logic                 tc_out
);
	// ************************************************************
	// Properties, one clock domain
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_run_loads_period: assert property (
		clk_en && run_set |=> run_gate && count_register == $past(period_val))
		else $error("run set did not load period");
	// Only a one-step decrement or a reload may change the count
	a_count_steps_down: assert property (
		count_register != $past(count_register) |->
		count_register == $past(count_register) - 1'h1 ||
		count_register == $past(period_val))
		else $error("count moved other than down or reload");
	a_halted_sticky: assert property (
		status_r.halted_flag && !status_clr.halted_flag |=> status_r.halted_flag)
		else $error("halted flag dropped without clear");
	a_stop_irq_out: assert property (
		$rose(status_r.halted_flag) && irq_en.stop |=> irq_out)
		else $error("stop interrupt missing");
	a_read16_capture: assert property (
		clk_en && rd_cnt16 && !cfg.pwm_mode |=> rd_data == $past(count_register)
		&& capture_r == $past(count_register))
		else $error("16-bit read not coherent");
	a_readlo_capture: assert property (
		clk_en && rd_cnt_lo && !cfg.pwm_mode |=> capture_r ==
		$past(count_register) && rd_data[7:0] == $past(count_register[7:0]))
		else $error("low byte read did not capture count");
	a_pwm_count_hidden: assert property (
		clk_en && rd_cnt16 && cfg.pwm_mode |=> rd_data == $past(compare_val)
		&& $stable(capture_r))
		else $error("count readable in comparator mode");
	a_eq_one_cycle: assert property (
		clk_en && cfg.pwm_mode && cfg.submode == gtp_pkg::CMP_EQ
		&& $stable(cfg) && cmp_out |=> !cmp_out)
		else $error("equal compare pulse too long");
	// Settle time allows for a registered output stage
	a_dead_time_inv: assert property (
		$stable(cfg)[*3] ##0 (cfg.pwm_mode && cfg.dead_time_on)
		|-> tc_out == !cmp_out)
		else $error("tc output not complement of compare");
endmodule : gtp_timer_checker

bind gtp_timer gtp_timer_checker #(.W(W)) chk (.*);

// ===== tb/gtp_pin_src.sv
// Far-side model: interconnect driving the measured enable signal
`timescale 1ns/10ps
module gtp_pin_src (
	// Clock
	input  wire logic clk,
	// Measured signal
	output logic      enable_pin
);
	// Idle low; edges move just after a falling clock edge
	initial enable_pin = 1'h0;
	task automatic pulse(int hi, int lo);
		@(negedge clk);
		enable_pin = 1'h1;
		repeat (hi) @(negedge clk);
		enable_pin = 1'h0;
		repeat (lo) @(negedge clk);
	endtask : pulse
endmodule : gtp_pin_src

// ===== tb/tb_gtp_timer.sv
// Self-checking testbench for the gated timer / PWM block
`timescale 1ns/10ps
module tb_gtp_timer;
	logic                 clk = 1'h0;
	logic                 reset_n = 1'h0;
	logic                 clk_en = 1'h1;
	gtp_pkg::gtp_cfg_t    cfg = '0;
	gtp_pkg::gtp_irq_en_t irq_en = '0;
	gtp_pkg::gtp_status_t status_clr = '0;
	gtp_pkg::gtp_status_t status_r;
	logic [15:0]          period_val = 16'h0100;
	logic [15:0]          compare_val = 16'h0008;
	logic [15:0]          count_register, rd_data, capture_r;
	logic                 run_set = 1'h0, run_clr = 1'h0;
	logic                 rd_cnt16 = 1'h0, rd_cnt_lo = 1'h0;
	logic                 enable_pin, run_gate, irq_out, cmp_out, tc_out;
	int                   bad_count = 0, tests_run = 0, n;
	int                   widths [5] = '{1, 8, 9, 24, 25};

	always #2.5 clk = ~clk;
	gtp_timer #(.W(16)) uut (.*);
	gtp_pin_src pin (.*);

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic cyc(int k);
		repeat (k) @(negedge clk);
	endtask : cyc
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	// Clear all flags, then restart the gate so count reloads
	task automatic start;
		status_clr = '1;
		run_clr = 1'h1;
		cyc(1);
		status_clr = '0;
		run_clr = 1'h0;
		run_set = 1'h1;
		cyc(1);
		run_set = 1'h0;
	endtask : start
	task automatic rd(logic lo);
		rd_cnt_lo = lo;
		rd_cnt16 = !lo;
		cyc(1);
		rd_cnt_lo = 1'h0;
		rd_cnt16 = 1'h0;
	endtask : rd
	// Bounded wait on halted flag, run gate or compare output
	task automatic wait_sig(int s, logic lvl);
		n = 0;
		while ((s == 0 ? status_r.halted_flag : s == 1 ? run_gate : cmp_out)
			!== lvl && n < 3000) begin
			cyc(1);
			n++;
		end
		if (n == 3000) begin
			bad_count++;
			end_of_test();
		end
	endtask : wait_sig

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		cyc(16);
		reset_n = 1'h1;
		cfg.submode = gtp_pkg::SUB_PULSE;
		irq_en.stop = 1'h1;
		start();
		check("gate", run_gate, 16'h1);
		check("load", count_register, 16'h0100);
		pin.pulse(20, 10);
		wait_sig(0, 1'h1);
		cyc(2);
		check("pulse", count_register, 16'h00ec);
		check("stop irq", irq_out, 16'h1);
		status_clr = '1;
		cyc(1);
		status_clr = '0;
		check("halt clr", status_r.halted_flag, 16'h0);
		pin.pulse(5, 5);
		wait_sig(0, 1'h1);
		check("restart", count_register, 16'h00e7);
		rd(1'h0);
		check("rd16", rd_data, 16'h00e7);
		check("cap16", capture_r, 16'h00e7);
		rd(1'h1);
		check("rdlo", rd_data, 16'h00e7);
		check("caplo", capture_r, 16'h00e7);
		cfg.submode = gtp_pkg::SUB_PERIOD;
		cfg.one_shot = 1'h1;
		start();
		pin.pulse(12, 18);
		pin.pulse(4, 4);
		wait_sig(0, 1'h1);
		cyc(2);
		check("period", count_register, 16'h00e1);
		check("one shot", run_gate, 16'h0);
		cfg = '0;
		cfg.submode = gtp_pkg::SUB_IRQ;
		irq_en = 3'h4;
		period_val = 16'h0010;
		start();
		wait_sig(1, 1'h0);
		check("irq stop", status_r.tc, 16'h1);
		period_val = 16'h0020;
		irq_en = 3'h2;
		cfg = '0;
		cfg.pwm_mode = 1'h1;
		cfg.dead_time_on = 1'h1;
		for (int m = 0; m < 5; m++) begin
			cfg.submode = 3'(m);
			start();
			wait_sig(2, 1'h0);
			wait_sig(2, 1'h1);
			wait_sig(2, 1'h0);
			check("width", 16'(n), 16'(widths[m]));
		end
		check("cmp flag", status_r.cmp, 16'h1);
		rd(1'h0);
		check("pwm read", rd_data, 16'h0008);
		end_of_test();
	end
endmodule : tb_gtp_timer
